/* File: include/stream_pkg.sv */
// shared types and constants for the streaming spi master engine
package stream_pkg;
   localparam int SYS_CLK_PERIOD_NS = 50;
   localparam int WORD_MAX          = 32;
   localparam int CNT_W             = 16;
   localparam int LEN_W             = 16;
   localparam int BYTE_W            = 8;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [7:0]  PAD_BYTE  = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_LOW   = 3'b010,
      ST_HIGH  = 3'b011,
      ST_HOLD  = 3'b100,
      ST_GAP   = 3'b101,
      ST_DONE  = 3'b110
   } spi_state_e;

   // stream settings, all intervals in system clock periods
   typedef struct packed {
      logic [5:0]       num_bits;     // 1..32 bits per operation
      logic [31:0]      mosi_pat;     // supplied bytes in the low end
      logic [2:0]       mosi_bytes;   // 0..4 bytes supplied
      logic [CNT_W-1:0] sclk_low;
      logic [CNT_W-1:0] sclk_high;
      logic [CNT_W-1:0] cs_to_sclk;
      logic [CNT_W-1:0] sclk_to_cs;
      logic [CNT_W-1:0] cs_gap;
      logic [31:0]      num_samples;  // 0 means continuous
      logic [LEN_W-1:0] packet_size;
   } stream_cfg_s;

   typedef struct packed {
      logic [7:0] data;
      logic       valid;
      logic       last;
   } rd_beat_s;

   localparam stream_cfg_s CFG_RESET = '0;
   localparam rd_beat_s    BEAT_RESET = '0;
endpackage

/* File: logic/spi_stream_master_engine.sv */
// streaming spi master with onboard sample buffer and packetised host reads
`timescale 1ns/1ps
`default_nettype none

module spi_stream_master_engine import stream_pkg::*; #(
   parameter int DEPTH = 1024
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   // host commands and settings
   input  wire logic        start_i,
   input  wire logic        stop_i,
   input  wire stream_cfg_s cfg_i,
   // host read port
   input  wire logic        rd_req_i,
   input  wire logic [15:0] rd_len_i,
   output rd_beat_s         rd_beat_o,
   // status
   output logic             streaming_o,
   output logic             overflow_o,
   // spi pins
   output logic             sclk_o,
   output logic             cs_n_o,
   output logic             mosi_o,
   input  wire logic        miso_i
);
   localparam int PTR_W  = $clog2(DEPTH);
   localparam int FILL_W = PTR_W + 1;
   localparam logic [FILL_W-1:0] DEPTH_F = FILL_W'(DEPTH);

   // spi sequencer state
   spi_state_e       st_r, st_nxt;
   stream_cfg_s      cfg_r, cfg_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [5:0]       bit_r, bit_nxt;
   logic [31:0]      tx_r, tx_nxt;
   logic [31:0]      rx_r, rx_nxt;
   logic [31:0]      nsmp_r, nsmp_nxt;
   logic             sclk_r, sclk_nxt;
   logic             csn_r, csn_nxt;
   logic             mosi_r, mosi_nxt;
   logic             stop_pend_r, stop_pend_nxt;
   logic             smp_done_r, smp_done_nxt;
   logic             flush_r, flush_nxt;
   logic             fin_r, fin_nxt;
   logic             go_r, go_nxt;
   logic             stream_r, stream_nxt;
   logic             cnt_end;
   logic [31:0]      aligned;

   // buffer and read state
   logic [7:0]        mem [DEPTH];
   logic [PTR_W-1:0]  wp_r, wp_nxt, rp_r, rp_nxt;
   logic [FILL_W-1:0] fill_r, fill_nxt;
   logic [2:0]        pcnt_r, pcnt_nxt;
   logic [31:0]       pword_r, pword_nxt;
   logic              odd_r, odd_nxt;
   logic              pad_r, pad_nxt;
   logic              ovf_r, ovf_nxt;
   logic [15:0]       rem_r, rem_nxt;
   rd_beat_s          beat_r, beat_nxt;
   logic              push;
   logic [7:0]        push_byte;
   logic              pop;
   logic [15:0]       n_len;

   assign cnt_end = (cnt_r <= CNT_W'(1));
   // pattern bytes sit at the top of the shift word, zeros below
   assign aligned = (cfg_r.mosi_bytes == 3'h0) ? ZERO_WORD
                  : cfg_r.mosi_pat << (6'd32 - {cfg_r.mosi_bytes, 3'h0});

   always_comb begin
      st_nxt        = st_r;
      cfg_nxt       = cfg_r;
      cnt_nxt       = cnt_r;
      bit_nxt       = bit_r;
      tx_nxt        = tx_r;
      rx_nxt        = rx_r;
      nsmp_nxt      = nsmp_r;
      sclk_nxt      = sclk_r;
      csn_nxt       = csn_r;
      mosi_nxt      = mosi_r;
      stop_pend_nxt = stop_pend_r | (stop_i & (st_r != ST_IDLE));
      smp_done_nxt  = 1'b0;
      flush_nxt     = 1'b0;
      fin_nxt       = 1'b0;
      go_nxt        = 1'b0;
      unique case (st_r)
         ST_IDLE: begin
            if (start_i) begin
               cfg_nxt       = cfg_i;
               go_nxt        = 1'b1;
               nsmp_nxt      = ZERO_WORD;
               stop_pend_nxt = 1'b0;
               st_nxt        = ST_GAP;
               cnt_nxt       = CNT_W'(1);
            end
         end
         ST_SETUP: begin
            if (cnt_end) begin
               st_nxt   = ST_LOW;
               mosi_nxt = tx_r[31];
               tx_nxt   = {tx_r[30:0], 1'b0};
               cnt_nxt  = cfg_r.sclk_low;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_LOW: begin
            if (cnt_end) begin
               st_nxt   = ST_HIGH;
               sclk_nxt = 1'b1;
               rx_nxt   = {rx_r[30:0], miso_i};
               bit_nxt  = bit_r - 6'h1;
               cnt_nxt  = cfg_r.sclk_high;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_HIGH: begin
            if (cnt_end) begin
               sclk_nxt = 1'b0;
               if (bit_r == 6'h0) begin
                  st_nxt  = ST_HOLD;
                  cnt_nxt = cfg_r.sclk_to_cs;
               end else begin
                  st_nxt   = ST_LOW;
                  mosi_nxt = tx_r[31];
                  tx_nxt   = {tx_r[30:0], 1'b0};
                  cnt_nxt  = cfg_r.sclk_low;
               end
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_HOLD: begin
            if (cnt_end) begin
               csn_nxt      = 1'b1;
               mosi_nxt     = 1'b0;
               smp_done_nxt = 1'b1;
               nsmp_nxt     = nsmp_r + 32'h1;
               st_nxt       = ST_GAP;
               cnt_nxt      = cfg_r.cs_gap;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_GAP: begin
            if (stop_pend_r || stop_i) begin
               st_nxt    = ST_IDLE;
               flush_nxt = 1'b1;
            end else if ((cfg_r.num_samples != ZERO_WORD) && (nsmp_r == cfg_r.num_samples)) begin
               st_nxt  = ST_DONE;
               fin_nxt = 1'b1;
            end else if (cnt_end) begin
               st_nxt  = ST_SETUP;
               csn_nxt = 1'b0;
               cnt_nxt = cfg_r.cs_to_sclk;
               tx_nxt  = aligned;
               bit_nxt = cfg_r.num_bits;
               rx_nxt  = ZERO_WORD;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_DONE: begin
            if (stop_pend_r || stop_i) begin
               st_nxt    = ST_IDLE;
               flush_nxt = 1'b1;
            end
         end
         default: begin
            st_nxt  = ST_IDLE;
            csn_nxt = 1'b1;
         end
      endcase
      // registered copy of the state decode for the status pin
      stream_nxt = (st_nxt != ST_IDLE);
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_r        <= ST_IDLE;
         cfg_r       <= CFG_RESET;
         cnt_r       <= '0;
         bit_r       <= '0;
         tx_r        <= '0;
         rx_r        <= '0;
         nsmp_r      <= '0;
         sclk_r      <= 1'b0;
         csn_r       <= 1'b1;
         mosi_r      <= 1'b0;
         stop_pend_r <= 1'b0;
         smp_done_r  <= 1'b0;
         flush_r     <= 1'b0;
         fin_r       <= 1'b0;
         go_r        <= 1'b0;
         stream_r    <= 1'b0;
      end else begin
         st_r        <= st_nxt;
         cfg_r       <= cfg_nxt;
         cnt_r       <= cnt_nxt;
         bit_r       <= bit_nxt;
         tx_r        <= tx_nxt;
         rx_r        <= rx_nxt;
         nsmp_r      <= nsmp_nxt;
         sclk_r      <= sclk_nxt;
         csn_r       <= csn_nxt;
         mosi_r      <= mosi_nxt;
         stop_pend_r <= stop_pend_nxt;
         smp_done_r  <= smp_done_nxt;
         flush_r     <= flush_nxt;
         fin_r       <= fin_nxt;
         go_r        <= go_nxt;
         stream_r    <= stream_nxt;
      end
   end

   // byte pusher, fifo pointers and host read answers
   always_comb begin
      pcnt_nxt  = pcnt_r;
      pword_nxt = pword_r;
      odd_nxt   = odd_r;
      pad_nxt   = pad_r | fin_r;
      ovf_nxt   = ovf_r;
      rem_nxt   = rem_r;
      beat_nxt  = BEAT_RESET;
      push      = 1'b0;
      push_byte = PAD_BYTE;
      n_len     = rd_len_i;
      if (pcnt_r != 3'h0) begin
         push      = 1'b1;
         push_byte = 8'(pword_r >> {pcnt_r - 3'h1, 3'h0});
         pcnt_nxt  = pcnt_r - 3'h1;
      end else if (pad_r) begin
         pad_nxt = 1'b0;
         push    = odd_r;
      end
      if (smp_done_r) begin
         pword_nxt = rx_r;
         pcnt_nxt  = 3'((7'(cfg_r.num_bits) + 7'd7) >> 3);
      end
      if (push && (fill_r == DEPTH_F)) begin
         ovf_nxt = 1'b1;
      end
      if (push && (fill_r != DEPTH_F)) begin
         odd_nxt = ~odd_r;
      end
      pop = (rem_r != 16'h0);
      if (pop) begin
         beat_nxt.data  = mem[rp_r];
         beat_nxt.valid = 1'b1;
         beat_nxt.last  = (rem_r == 16'h1);
         rem_nxt        = rem_r - 16'h1;
      end else if (rd_req_i) begin
         if (cfg_r.packet_size < n_len) n_len = cfg_r.packet_size;
         if (16'(fill_r) < n_len) n_len = 16'(fill_r);
         rem_nxt       = n_len;
         beat_nxt.last = (n_len == 16'h0);
      end
      wp_nxt   = (push && (fill_r != DEPTH_F)) ? wp_r + PTR_W'(1) : wp_r;
      rp_nxt   = pop ? rp_r + PTR_W'(1) : rp_r;
      fill_nxt = fill_r + FILL_W'(push && (fill_r != DEPTH_F)) - FILL_W'(pop);
      if (go_r) begin
         ovf_nxt = 1'b0;
         odd_nxt = 1'b0;
      end
      if (flush_r) begin
         wp_nxt   = '0;
         rp_nxt   = '0;
         fill_nxt = '0;
         pcnt_nxt = '0;
         pad_nxt  = 1'b0;
         rem_nxt  = '0;
         beat_nxt = BEAT_RESET;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push && (fill_r != DEPTH_F)) mem[wp_r] <= push_byte;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         wp_r    <= '0;
         rp_r    <= '0;
         fill_r  <= '0;
         pcnt_r  <= '0;
         pword_r <= '0;
         odd_r   <= 1'b0;
         pad_r   <= 1'b0;
         ovf_r   <= 1'b0;
         rem_r   <= '0;
         beat_r  <= BEAT_RESET;
      end else begin
         wp_r    <= wp_nxt;
         rp_r    <= rp_nxt;
         fill_r  <= fill_nxt;
         pcnt_r  <= pcnt_nxt;
         pword_r <= pword_nxt;
         odd_r   <= odd_nxt;
         pad_r   <= pad_nxt;
         ovf_r   <= ovf_nxt;
         rem_r   <= rem_nxt;
         beat_r  <= beat_nxt;
      end
   end

   assign rd_beat_o   = beat_r;
   assign streaming_o = stream_r;
   assign overflow_o  = ovf_r;
   assign sclk_o      = sclk_r;
   assign cs_n_o      = csn_r;
   assign mosi_o      = mosi_r;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   a_start_enters: assert property (start_i && st_r == ST_IDLE |=> st_r == ST_GAP ##1 st_r == ST_SETUP)
      else $error("start did not begin an operation");
   a_stay_stream: assert property (streaming_o && !stop_i && !stop_pend_r |=> streaming_o)
      else $error("streaming left without stop");
   a_first_bit: assert property (st_r == ST_SETUP && cnt_end |=> mosi_o == $past(tx_r[31]))
      else $error("mosi does not follow pattern");
   a_sclk_in_cs: assert property (sclk_o |-> !cs_n_o)
      else $error("sclk toggled outside chip select");
   a_stop_finish: assert property (stop_i && (st_r == ST_LOW || st_r == ST_HIGH) |=> st_r != ST_IDLE)
      else $error("stop cut an operation short");
   a_flush_empty: assert property (flush_r |=> fill_r == '0 && rem_r == 16'h0)
      else $error("unread data survived stop");
   a_read_bound: assert property (rd_req_i && rem_r == 16'h0 |=> rem_r <= $past(rd_len_i)
      && rem_r <= cfg_r.packet_size)
      else $error("read answer longer than allowed");
   a_even_total: assert property (st_r == ST_DONE && pcnt_r == 3'h0 && !pad_r && !fin_r |-> !odd_r)
      else $error("finite run left odd byte total");
   a_ovf_sticky: assert property (overflow_o && !go_r |=> overflow_o)
      else $error("overflow flag lost");
   a_pad_top: assert property (smp_done_r |=> pcnt_r == 3'((7'(cfg_r.num_bits) + 7'd7) >> 3))
      else $error("sample byte count wrong");

   c_started: cover property (start_i && st_r == ST_IDLE ##[1:40] smp_done_r);
   c_overflow: cover property ($rose(overflow_o));
   c_read_packet: cover property (rd_beat_o.valid && rd_beat_o.last);
   c_pad_push: cover property (pad_r && pcnt_r == 3'h0 && odd_r);
endmodule

`default_nettype wire

/* File: verification/spi_slave_model.sv */
// spi slave model: answers a fixed word msb first and captures mosi per operation
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model #(
   parameter logic [31:0] RESP = 32'hc3a5_5a96
) (
   // spi pins
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        mosi_i,
   output logic             miso_o,
   // observation
   output logic [31:0]      rx_word_o,
   output int               bits_o,
   output int               ops_o
);
   logic [31:0] tx_sr;
   logic [31:0] rx_sr;
   int          cnt;

   initial begin
      miso_o = 1'b0;
      rx_word_o = 32'h0000_0000;
      bits_o = 0;
      ops_o = 0;
      tx_sr = RESP;
      rx_sr = 32'h0000_0000;
      cnt = 0;
   end

   always @(negedge cs_n_i) begin
      tx_sr = RESP;
      rx_sr = 32'h0000_0000;
      cnt = 0;
      miso_o = RESP[31];
   end

   // mode 0: master samples on the rise, so capture there and shift on the fall
   always @(posedge sclk_i) if (cs_n_i == 1'b0) begin
      rx_sr = {rx_sr[30:0], mosi_i};
      cnt++;
   end

   always @(negedge sclk_i) if (cs_n_i == 1'b0) begin
      tx_sr = tx_sr << 1;
      miso_o = tx_sr[31];
   end

   // deselected: show the inverse so a stale bit is never sampled as good
   always @(posedge cs_n_i) begin
      miso_o = ~miso_o;
      if (cnt > 0) begin
         rx_word_o = rx_sr;
         bits_o = cnt;
         ops_o++;
      end
   end
endmodule
`default_nettype wire

/* File: verification/spi_stream_master_engine_tb_top.sv */
// self-checking bench for the streaming spi master engine
`timescale 1ns/1ps
`default_nettype none
module spi_stream_master_engine_tb_top;
   import stream_pkg::*;
   localparam logic [31:0] RESP  = 32'hc3a5_5a96;
   localparam int          DEPTH = 16;
   typedef struct {int nb; logic [31:0] pat; int mb; int ns; logic [31:0] mosi;} row_s;

   logic        sys_clk;
   logic        srst;
   logic        start;
   logic        stop;
   stream_cfg_s cfg;
   logic        rd_req;
   logic [15:0] rd_len;
   rd_beat_s    beat;
   logic        streaming;
   logic        overflow;
   logic        sclk;
   logic        cs_n;
   logic        mosi;
   logic        miso;
   logic [31:0] rx_word;
   logic [31:0] smp;
   int          bits;
   int          ops;
   int          failures;
   int          n_checks;
   int          hi_w;
   int          hi_cnt;
   int          base;
   int          nby;
   logic [7:0]  got[$];
   logic [7:0]  exp[$];
   row_s        rows[5] = '{'{8, 32'h0000_00a5, 1, 3, 32'h0000_00a5}, '{12, 32'h0000_0000, 0, 2, 32'h0000_0000},
                            '{16, 32'h0000_003c, 1, 2, 32'h0000_3c00}, '{24, 32'h0000_abcd, 2, 1, 32'h00ab_cd00},
                            '{32, 32'h1234_5678, 4, 1, 32'h1234_5678}};

   spi_stream_master_engine #(.DEPTH(DEPTH)) u_spi_stream_master_engine (
      .sys_clk_i(sys_clk), .srst_i(srst), .start_i(start), .stop_i(stop), .cfg_i(cfg),
      .rd_req_i(rd_req), .rd_len_i(rd_len), .rd_beat_o(beat), .streaming_o(streaming),
      .overflow_o(overflow), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

   spi_slave_model #(.RESP(RESP)) u_spi_slave_model (
      .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
      .rx_word_o(rx_word), .bits_o(bits), .ops_o(ops));

   always #25 sys_clk = ~sys_clk;

   // width of the last sclk high phase in system clocks
   always @(posedge sys_clk) begin
      if (sclk === 1'b1) hi_cnt++;
      else if (hi_cnt > 0) begin
         hi_w = hi_cnt;
         hi_cnt = 0;
      end
   end

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: value %h, wanted %h", $time, g, e);
      end
   endtask

   task automatic chk_flag(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, g, e);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic ran_out;
      failures++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict();
   endtask

   task automatic start_run(input int nb, input logic [31:0] pat, input int mb, input int ns, input int pk);
      stream_cfg_s c;
      c = CFG_RESET;
      c.num_bits = 6'(nb);
      c.mosi_pat = pat;
      c.mosi_bytes = 3'(mb);
      c.sclk_low = 16'h0002;
      c.sclk_high = 16'h0003;
      c.cs_to_sclk = 16'h0001;
      c.sclk_to_cs = 16'h0001;
      c.cs_gap = 16'h0001;
      c.num_samples = 32'(ns);
      c.packet_size = 16'(pk);
      @(posedge sys_clk);
      cfg <= c;
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
   endtask

   task automatic wait_ops(input int n);
      for (int i = 0; i < 20000; i++) begin
         @(negedge sys_clk);
         if (ops >= n) return;
      end
      ran_out();
   endtask

   task automatic read_buf(input int len);
      got.delete();
      @(posedge sys_clk);
      rd_req <= 1'b1;
      rd_len <= 16'(len);
      @(posedge sys_clk);
      rd_req <= 1'b0;
      for (int i = 0; i < 100; i++) begin
         @(negedge sys_clk);
         if (beat.valid === 1'b1) got.push_back(beat.data);
         if (beat.last === 1'b1) return;
      end
      ran_out();
   endtask

   task automatic stop_run;
      @(posedge sys_clk);
      stop <= 1'b1;
      @(posedge sys_clk);
      stop <= 1'b0;
      for (int i = 0; i < 2000; i++) begin
         @(negedge sys_clk);
         if (streaming === 1'b0) return;
      end
      ran_out();
   endtask

   initial begin
      sys_clk = 1'b0;
      srst = 1'b1;
      start = 1'b0;
      stop = 1'b0;
      cfg = CFG_RESET;
      rd_req = 1'b0;
      rd_len = 16'h0000;
      failures = 0;
      n_checks = 0;
      hi_w = 0;
      hi_cnt = 0;
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      @(negedge sys_clk);
      chk_flag(cs_n, 1'b1);
      chk_flag(sclk, 1'b0);
      chk_flag(streaming, 1'b0);
      chk_flag(overflow, 1'b0);
      chk_flag(beat.valid, 1'b0);
      foreach (rows[r]) begin
         base = ops;
         start_run(rows[r].nb, rows[r].pat, rows[r].mb, rows[r].ns, 16);
         wait_ops(base + rows[r].ns);
         repeat (12) @(negedge sys_clk);
         exp.delete();
         smp = RESP >> (32 - rows[r].nb);
         nby = (rows[r].nb + 7) / 8;
         for (int s = 0; s < rows[r].ns; s++)
            for (int k = nby - 1; k >= 0; k--) exp.push_back(smp[8*k +: 8]);
         if (exp.size() % 2 == 1) exp.push_back(PAD_BYTE);
         read_buf(16);
         chk_word(got.size(), exp.size());
         foreach (exp[i]) chk_word(got[i], exp[i]);
         chk_word(rx_word, rows[r].mosi);
         chk_word(bits, rows[r].nb);
         chk_word(hi_w, 3);
         stop_run();
      end
      // continuous 4-byte samples into a 16-byte buffer
      base = ops;
      start_run(32, 32'h0000_0000, 0, 0, 16);
      wait_ops(base + 6);
      repeat (12) @(negedge sys_clk);
      chk_flag(overflow, 1'b1);
      read_buf(16);
      chk_word(got.size(), 16);
      chk_word(got[0], RESP[31:24]);
      // stop in the middle of an operation
      for (int i = 0; i < 200; i++) begin
         @(negedge sys_clk);
         if (cs_n === 1'b0 && sclk === 1'b1) break;
      end
      stop_run();
      chk_word(bits, 32);
      chk_flag(cs_n, 1'b1);
      read_buf(16);
      chk_word(got.size(), 0);
      chk_flag(streaming, 1'b0);
      // packet size limit while the bus keeps running
      base = ops;
      start_run(8, 32'h0000_005a, 1, 0, 2);
      repeat (3) @(negedge sys_clk);
      chk_flag(overflow, 1'b0);
      wait_ops(base + 5);
      repeat (12) @(negedge sys_clk);
      read_buf(16);
      chk_word(got.size(), 2);
      read_buf(1);
      chk_word(got.size(), 1);
      chk_word(got[0], RESP[31:24]);
      chk_word(hi_w, 3);
      // second start while streaming must not change the waveform
      start_run(16, 32'h0000_00ff, 1, 0, 2);
      base = ops;
      wait_ops(base + 2);
      chk_word(bits, 8);
      chk_word(rx_word, 32'h0000_005a);
      chk_flag(streaming, 1'b1);
      stop_run();
      give_verdict();
   end
endmodule
`default_nettype wire
